//--- shared/amc_pkg.sv
// Package of constants for the analog mode control block
package amc_pkg;
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int LOGIC_CLK_HZ = 1_000_000;
    localparam int LOGIC_DIV = CLK_FREQ_HZ / LOGIC_CLK_HZ;
    localparam int PHASE_T2 = 25;
    localparam int PHASE_T3 = 50;
    localparam int PHASE_T4 = 75;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
    localparam logic [31:0] ADDR_IRQ_STAT = 32'h0000_0008;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'h0000_000c;
    localparam int CTRL_IC = 0;
    localparam int CTRL_OP = 1;
    localparam int CTRL_HOLD = 2;
    localparam int CTRL_AUTO_HOLD = 3;
    localparam int CTRL_TIMER_EXEC = 4;
    localparam int CTRL_SWAP = 5;
    localparam int CTRL_LOGIC_RUN = 6;
    localparam int CTRL_W = 7;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h01;
    localparam int IRQ_OVERLOAD = 0;
    localparam int IRQ_W = 1;
    typedef enum logic [1:0] {
        AMC_IC = 2'b00,
        AMC_OP = 2'b01,
        AMC_HOLD = 2'b11
    } amc_mode_t;
endpackage

//--- rtl/amc_override.sv
// Patchable override points, one per integrator
module amc_override
    import amc_pkg::*;
#(
    parameter int N = 4
) (
    input wire logic [N-1:0] i_default,
    input wire logic [N-1:0] i_patched,
    input wire logic [N-1:0] i_patch_present,
    output logic [N-1:0] o_value
);
    for (genvar g = 0; g < N; g++) begin : g_ovr
        // Patched source wins regardless of either level
        assign o_value[g] = i_patch_present[g] ? i_patched[g] : i_default[g];
    end
endmodule

//--- rtl/amc_two_phase.sv
// Two-phase clock generator and master/slave stage model
module amc_two_phase
    import amc_pkg::*;
#(
    parameter int DIV = LOGIC_DIV,
    parameter int W = 4
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_run,
    input wire logic [W-1:0] i_d,
    output logic o_input_stage_clock,
    output logic o_output_stage_clock,
    output logic [W-1:0] o_q
);
    logic [6:0] phase;
    logic [W-1:0] master;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            phase <= 7'h00;
        end else if (!i_run) begin
            phase <= 7'h00;
        end else if (phase == 7'(DIV - 1)) begin
            phase <= 7'h00;
        end else begin
            phase <= phase + 7'h01;
        end
    end

    // Master samples between T2 and T3 only
    assign o_input_stage_clock = i_run && phase >= 7'(PHASE_T2) && phase < 7'(PHASE_T3);
    // Slave opens after T4; window never overlaps master
    assign o_output_stage_clock = i_run && phase >= 7'(PHASE_T4);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            master <= '0;
        end else if (o_input_stage_clock) begin
            master <= i_d;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_q <= '0;
        end else if (o_output_stage_clock) begin
            o_q <= master;
        end
    end

    a_phase_apart: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !(o_input_stage_clock && o_output_stage_clock))
        else $error("Stage clocks overlap");
    a_master_lock: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !o_input_stage_clock |=> $stable(master))
        else $error("Master changed while locked");
    a_slave_lock: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !o_output_stage_clock |=> $stable(o_q))
        else $error("Slave changed while locked");
    a_period_1us: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_run && phase == 7'h00) [*1] ##1 i_run [*8] |-> phase == 7'h08)
        else $error("Phase counter rate wrong");
endmodule

//--- rtl/amc_mode_ctrl.sv
// Analog mode control: mode bus, master hold, auto hold, test swap, APB
// How it works
// - A patched override signal replaces the default, whatever its level.
// - IC gives hold 0 op 0; operate hold 0 op 1; hold gives hold 1.
// - Integrator switches follow the mode bus driven by the hold and operate panel selections, IC when neither.
// - Master hold forces every integrator to hold, above any override.
// - Auto hold enabled plus any overload asserts the master hold bus.
// - Without timer execution, an auto hold freezes analog only.
// - With timer execution, an auto hold freezes analog and logic clocking.
// - Auto hold stays latched until the operator releases auto hold.
// - After release, switches return to what the mode bus commands now.
// - Test swap engaged: test terminals to reference, init terminals grounded.
// - Test swap released: init terminals to reference, test terminals grounded.
// - Master stage samples only in its window, then locks for the period.
// - Slave stage copies master only in its own window, locked otherwise.
// - Timer execution ignores panel modes; the timer state drives the mode bus.
// - Two-phase stage clocks run at 1 MHz while logic runs.
module amc_mode_ctrl
    import amc_pkg::*;
#(
    parameter int N_INT = 4,
    parameter int N_OVL = 8
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [N_OVL-1:0] i_overload,
    input wire logic [1:0] i_timer_state,
    input wire logic [N_INT-1:0] i_patch_hold,
    input wire logic [N_INT-1:0] i_patch_hold_present,
    input wire logic [N_INT-1:0] i_patch_op,
    input wire logic [N_INT-1:0] i_patch_op_present,
    input wire logic [N_INT-1:0] i_logic_d,
    output logic [N_INT-1:0] o_int_hold,
    output logic [N_INT-1:0] o_int_op,
    output logic o_master_hold,
    output logic o_auto_hold_latched,
    output logic o_positive_test_terminal,
    output logic o_negative_test_terminal,
    output logic o_positive_init_terminal,
    output logic o_negative_init_terminal,
    output logic o_input_stage_clock,
    output logic o_output_stage_clock,
    output logic [N_INT-1:0] o_logic_q,
    output logic o_irq
);
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [N_OVL-1:0] ovl_meta;
    logic [N_OVL-1:0] ovl_sync;
    logic auto_latch;
    logic bus_hold;
    logic bus_op;
    amc_mode_t panel_mode;
    amc_mode_t next_bus_mode;
    logic [N_INT-1:0] ovr_hold;
    logic [N_INT-1:0] ovr_op;
    logic logic_run;
    logic wr_en;
    logic rd_en;
    logic addr_ok;

    // APB: zero wait states, unmapped addresses give pslverr
    assign addr_ok = i_paddr == ADDR_CTRL || i_paddr == ADDR_STATUS
        || i_paddr == ADDR_IRQ_STAT || i_paddr == ADDR_IRQ_MASK;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !addr_ok;
    assign wr_en = i_psel && i_penable && i_pwrite && addr_ok;
    // Latched at the setup edge, so read data stands through the access phase
    assign rd_en = i_psel && !i_penable && !i_pwrite;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl <= CTRL_RESET;
        end else if (wr_en && i_paddr == ADDR_CTRL) begin
            ctrl <= i_pwdata[CTRL_W-1:0];
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_mask <= '0;
        end else if (wr_en && i_paddr == ADDR_IRQ_MASK) begin
            irq_mask <= i_pwdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= '0;
        end else if (rd_en) begin
            unique case (i_paddr)
                ADDR_CTRL: o_prdata <= {25'h0, ctrl};
                ADDR_STATUS: o_prdata <= {29'h0, logic_run, auto_latch, o_master_hold};
                ADDR_IRQ_STAT: o_prdata <= {31'h0, irq_stat};
                ADDR_IRQ_MASK: o_prdata <= {31'h0, irq_mask};
                default: o_prdata <= '0;
            endcase
        end
    end

    // Overloads are asynchronous to the console clock
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ovl_meta <= '0;
            ovl_sync <= '0;
        end else begin
            ovl_meta <= i_overload;
            ovl_sync <= ovl_meta;
        end
    end

    // Only dropping the enable clears it
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            auto_latch <= 1'b0;
        end else if (!ctrl[CTRL_AUTO_HOLD]) begin
            auto_latch <= 1'b0;
        end else if (|ovl_sync) begin
            auto_latch <= 1'b1;
        end
    end

    // Set wins over a write-one clear
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_stat <= '0;
        end else begin
            for (int i = 0; i < IRQ_W; i++) begin
                if (ctrl[CTRL_AUTO_HOLD] && |ovl_sync && i == IRQ_OVERLOAD) begin
                    irq_stat[i] <= 1'b1;
                end else if (wr_en && i_paddr == ADDR_IRQ_STAT && i_pwdata[i]) begin
                    irq_stat[i] <= 1'b0;
                end
            end
        end
    end
    assign o_irq = |(irq_stat & irq_mask);

    // Hold button has priority over operate over IC on the panel
    always_comb begin
        if (ctrl[CTRL_HOLD]) begin
            panel_mode = AMC_HOLD;
        end else if (ctrl[CTRL_OP]) begin
            panel_mode = AMC_OP;
        end else begin
            panel_mode = AMC_IC;
        end
    end

    // Timer takes the bus during execution
    always_comb begin
        if (ctrl[CTRL_TIMER_EXEC]) begin
            next_bus_mode = amc_mode_t'(i_timer_state == 2'h2 ? AMC_HOLD
                : (i_timer_state == 2'h1 ? AMC_OP : AMC_IC));
        end else begin
            next_bus_mode = panel_mode;
        end
    end
    // Encoding: IC 00, operate 01, hold 1x
    assign bus_hold = next_bus_mode[1];
    assign bus_op = next_bus_mode[0];

    assign o_master_hold = auto_latch;
    assign o_auto_hold_latched = auto_latch;

    amc_override #(.N(N_INT)) u_ovr_hold (
        .i_default({N_INT{bus_hold}}),
        .i_patched(i_patch_hold),
        .i_patch_present(i_patch_hold_present),
        .o_value(ovr_hold)
    );
    amc_override #(.N(N_INT)) u_ovr_op (
        .i_default({N_INT{bus_op}}),
        .i_patched(i_patch_op),
        .i_patch_present(i_patch_op_present),
        .o_value(ovr_op)
    );

    // Master hold sits after the overrides so nothing escapes it
    // Combinational, so release returns to the live bus at once
    assign o_int_hold = ovr_hold | {N_INT{o_master_hold}};
    assign o_int_op = ovr_op;

    // Auto hold freezes logic only in timer execution
    assign logic_run = ctrl[CTRL_LOGIC_RUN] && !(auto_latch && ctrl[CTRL_TIMER_EXEC]);

    amc_two_phase #(.DIV(LOGIC_DIV), .W(N_INT)) u_phase (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_run(logic_run),
        .i_d(i_logic_d),
        .o_input_stage_clock(o_input_stage_clock),
        .o_output_stage_clock(o_output_stage_clock),
        .o_q(o_logic_q)
    );

    // Relay pairs swap together
    assign o_positive_test_terminal = ctrl[CTRL_SWAP];
    assign o_negative_test_terminal = ctrl[CTRL_SWAP];
    assign o_positive_init_terminal = !ctrl[CTRL_SWAP];
    assign o_negative_init_terminal = !ctrl[CTRL_SWAP];

    // Two synchroniser edges and one latch edge before hold shows
    sequence s_trip_armed;
        ctrl[CTRL_AUTO_HOLD] && |i_overload;
    endsequence
    sequence s_trip_kept;
        ctrl[CTRL_AUTO_HOLD] [*3];
    endsequence

    a_hold_forced: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_master_hold |-> &o_int_hold)
        else $error("Integrator out of hold under master hold");
    a_auto_trip: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_trip_armed ##1 s_trip_kept |-> o_master_hold)
        else $error("Overload did not trip hold");
    a_latch_keep: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (auto_latch && ctrl[CTRL_AUTO_HOLD]) |=> auto_latch || !$past(ctrl[CTRL_AUTO_HOLD]) ||
        !ctrl[CTRL_AUTO_HOLD])
        else $error("Auto hold cleared while enabled");
    a_release_bus: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(auto_latch) && !(|i_patch_hold_present) |-> o_int_hold == {N_INT{bus_hold}})
        else $error("Switches did not return to bus");
    a_ic_code: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (next_bus_mode == AMC_IC && !o_master_hold && !(|i_patch_hold_present)
        && !(|i_patch_op_present)) |-> o_int_hold == '0 && o_int_op == '0)
        else $error("IC encoding wrong");
    a_logic_freeze: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (auto_latch && ctrl[CTRL_TIMER_EXEC]) |-> !o_input_stage_clock && !o_output_stage_clock)
        else $error("Logic ran during exec auto hold");
    a_analog_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!ctrl[CTRL_TIMER_EXEC] && ctrl[CTRL_LOGIC_RUN]) |-> logic_run)
        else $error("Logic frozen without exec");
    a_timer_bus: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ctrl[CTRL_TIMER_EXEC] && i_timer_state == 2'h1) |-> next_bus_mode == AMC_OP)
        else $error("Timer not driving bus");
    a_swap_pair: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_positive_test_terminal != o_positive_init_terminal)
        else $error("Test and init terminals not complementary");

    // Mode bus codes at the switches with no patch, and panel buttons onto the bus
    a_op_code: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (next_bus_mode == AMC_OP && !o_master_hold && !(|i_patch_hold_present)
        && !(|i_patch_op_present)) |-> o_int_hold == '0 && o_int_op == '1)
        else $error("Operate encoding wrong");
    a_hold_code: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (next_bus_mode == AMC_HOLD && !(|i_patch_hold_present)) |-> &o_int_hold)
        else $error("Hold encoding wrong");
    a_panel_op: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!ctrl[CTRL_TIMER_EXEC] && ctrl[CTRL_OP] && !ctrl[CTRL_HOLD])
        |-> next_bus_mode == AMC_OP)
        else $error("Panel operate not on bus");
    a_panel_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!ctrl[CTRL_TIMER_EXEC] && ctrl[CTRL_HOLD]) |-> next_bus_mode == AMC_HOLD)
        else $error("Panel hold not on bus");

    // Each override bit: patched value when present, bus value otherwise
    a_patch_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !o_master_hold |-> o_int_hold == ((i_patch_hold & i_patch_hold_present)
        | ({N_INT{bus_hold}} & ~i_patch_hold_present)))
        else $error("Hold override wrong");
    a_patch_op: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_int_op == ((i_patch_op & i_patch_op_present)
        | ({N_INT{bus_op}} & ~i_patch_op_present)))
        else $error("Operate override wrong");

    // Relay pairs follow the swap bit together
    a_swap_on: assert property (@(posedge i_core_clk) disable iff (i_rst)
        ctrl[CTRL_SWAP] |-> o_positive_test_terminal && o_negative_test_terminal
        && !o_positive_init_terminal && !o_negative_init_terminal)
        else $error("Swap engaged terminals wrong");
    a_swap_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !ctrl[CTRL_SWAP] |-> !o_positive_test_terminal && !o_negative_test_terminal
        && o_positive_init_terminal && o_negative_init_terminal)
        else $error("Swap released terminals wrong");

    // Latch set by a synchronised overload, cleared only by the enable
    a_latch_set: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ctrl[CTRL_AUTO_HOLD] && |ovl_sync) |=> auto_latch)
        else $error("Latch missed overload");
    a_latch_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (auto_latch && ctrl[CTRL_AUTO_HOLD]) |=> auto_latch)
        else $error("Latch dropped while enabled");
    a_latch_clear: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !ctrl[CTRL_AUTO_HOLD] |=> !auto_latch)
        else $error("Latch kept after release");
    a_stat_set: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ctrl[CTRL_AUTO_HOLD] && |ovl_sync) |=> irq_stat[IRQ_OVERLOAD])
        else $error("Overload status not set");

    // Register bus: write lands, read data stands in the access phase
    a_ctrl_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (wr_en && i_paddr == ADDR_CTRL) |=> ctrl == $past(i_pwdata[CTRL_W-1:0]))
        else $error("Control write lost");
    a_rd_stand: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_psel && i_penable && !i_pwrite && i_paddr == ADDR_CTRL)
        |-> o_prdata == {25'h0, ctrl})
        else $error("Read data not valid in access");

    // Logic keeps running in timer execution until a trip
    a_exec_run: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (ctrl[CTRL_TIMER_EXEC] && ctrl[CTRL_LOGIC_RUN] && !auto_latch) |-> logic_run)
        else $error("Logic frozen without trip");
endmodule

//--- test/amc_switch_model.sv
// Integrator mode switch model: decodes switch inputs into modes
module amc_switch_model
    import amc_pkg::*;
#(
    parameter int N = 4
) (
    input wire logic [N-1:0] i_hold,
    input wire logic [N-1:0] i_op,
    output logic [2*N-1:0] o_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    // Hold wins, operate line then a don't-care
    always_comb begin
        for (int k = 0; k < N; k++) begin
            o_mode[2*k +: 2] = i_hold[k] ? AMC_HOLD : (i_op[k] ? AMC_OP : AMC_IC);
        end
    end
endmodule

//--- test/test_analog_mode_control.sv
// Self-checking testbench for the analog mode control block
module test_analog_mode_control
    import amc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk, i_rst, psel, penable, pwrite, pready, pslverr, irq, mhold, latched;
    logic isc, osc;
    logic [31:0] paddr, pwdata, prdata, q;
    logic [7:0] ovl, mode;
    logic [1:0] tstate;
    logic [3:0] ph, php, po, pop, ld, hold, op, lq, term;
    logic e;
    int errors = 0;
    int comparisons = 0;
    amc_mode_ctrl amc_mode_ctrl_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_overload(ovl),
        .i_timer_state(tstate), .i_patch_hold(ph), .i_patch_hold_present(php),
        .i_patch_op(po), .i_patch_op_present(pop), .i_logic_d(ld), .o_int_hold(hold),
        .o_int_op(op), .o_master_hold(mhold), .o_auto_hold_latched(latched),
        .o_positive_test_terminal(term[3]), .o_negative_test_terminal(term[2]),
        .o_positive_init_terminal(term[1]), .o_negative_init_terminal(term[0]),
        .o_input_stage_clock(isc), .o_output_stage_clock(osc), .o_logic_q(lq), .o_irq(irq));
    amc_switch_model amc_switch_model_i (.i_hold(hold), .i_op(op), .o_mode(mode));
    initial begin
        i_core_clk = 0;
        forever #5 i_core_clk = ~i_core_clk;
    end
    task automatic stop_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Master holds every signal until pready is seen at an edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        @(posedge i_core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors++;
            stop_test();
        end
    endtask
    // Read data stands from the setup edge, one transfer is enough
    task automatic rd(input logic [31:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    // Looked at on the falling edge, where combinational outputs have settled
    task automatic modes(input logic [1:0] m);
        @(negedge i_core_clk);
        chk("modes", {24'h0, {4{m}}}, {24'h0, mode});
        @(posedge i_core_clk);
    endtask
    // Two synchroniser edges plus the latch edge: hold seen at the fourth falling edge
    task automatic trip;
        int n;
        @(posedge i_core_clk);
        ovl <= 8'h20;
        n = 0;
        do begin
            @(negedge i_core_clk);
            n++;
        end while (mhold !== 1'b1 && n < 10);
        chk("master_hold", 1, mhold);
        chk("trip_delay", 4, n);
        @(posedge i_core_clk);
        ovl <= 8'h00;
    endtask
    task automatic rises(input int exp);
        int c;
        int k;
        logic p;
        logic r;
        c = 0;
        k = 0;
        p = isc;
        r = osc;
        repeat (200) begin
            @(posedge i_core_clk);
            if (isc === 1'b1 && p === 1'b0) c++;
            if (osc === 1'b1 && r === 1'b0) k++;
            p = isc;
            r = osc;
        end
        chk("input_stage_rises", exp, c);
        chk("output_stage_rises", exp, k);
    endtask
    task automatic t_modes;
        chk("terminals", 4'h3, term);
        modes(AMC_IC);
        apb(1'b1, ADDR_CTRL, 32'h2);
        modes(AMC_OP);
        apb(1'b1, ADDR_CTRL, 32'h4);
        modes(AMC_HOLD);
        apb(1'b1, ADDR_CTRL, 32'h1);
        modes(AMC_IC);
    endtask
    task automatic t_override;
        apb(1'b1, ADDR_CTRL, 32'h2);
        ph <= 4'h5;
        php <= 4'h3;
        po <= 4'h0;
        pop <= 4'hc;
        @(negedge i_core_clk);
        chk("hold", 4'h1, hold);
        chk("op", 4'h3, op);
    endtask
    task automatic t_auto;
        ph <= 4'h0;
        php <= 4'hf;
        po <= 4'hf;
        pop <= 4'hf;
        ld <= 4'ha;
        apb(1'b1, ADDR_CTRL, 32'h4a);
        trip();
        chk("hold", 4'hf, hold);
        repeat (20) @(posedge i_core_clk);
        chk("latched", 1, latched);
        rises(2);
        chk("logic_q", 4'ha, lq);
        rd(ADDR_STATUS);
        chk("status", 32'h7, q);
        chk("irq", 0, irq);
        rd(ADDR_IRQ_STAT);
        chk("irq_stat", 1, q);
        apb(1'b1, ADDR_IRQ_MASK, 32'h1);
        @(negedge i_core_clk);
        chk("irq", 1, irq);
        apb(1'b1, ADDR_IRQ_STAT, 32'h1);
        @(posedge i_core_clk);
        chk("irq", 0, irq);
        chk("latched", 1, latched);
        php <= 4'h0;
        pop <= 4'h0;
        apb(1'b1, ADDR_CTRL, 32'h41);
        repeat (2) @(negedge i_core_clk);
        chk("latched", 0, latched);
        modes(AMC_IC);
    endtask
    task automatic t_exec;
        logic [1:0] m [3];
        m = '{AMC_IC, AMC_OP, AMC_HOLD};
        apb(1'b1, ADDR_CTRL, 32'h51);
        for (int s = 0; s < 3; s++) begin
            tstate <= s[1:0];
            modes(m[s]);
        end
        tstate <= 2'h1;
        apb(1'b1, ADDR_CTRL, 32'h59);
        trip();
        ld <= 4'h5;
        rises(0);
        chk("logic_q", 4'ha, lq);
        apb(1'b1, ADDR_CTRL, 32'h1);
    endtask
    task automatic t_swap;
        apb(1'b1, ADDR_CTRL, 32'h21);
        @(posedge i_core_clk);
        chk("terminals", 4'hc, term);
        apb(1'b1, ADDR_CTRL, 32'h1);
        @(posedge i_core_clk);
        chk("terminals", 4'h3, term);
        apb(1'b1, 32'h10, 32'h7f);
        chk("pslverr", 1, e);
        chk("pready", 1, pready);
        rd(ADDR_CTRL);
        chk("ctrl", 32'h1, q);
    endtask
    initial begin
        i_rst = 1'b1;
        {psel, penable, pwrite} = 3'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        ovl = 8'h00;
        tstate = 2'h0;
        {ph, php, po, pop, ld} = 20'h0;
        repeat (6) @(posedge i_core_clk);
        i_rst <= 1'b0;
        t_modes();
        t_override();
        t_auto();
        t_exec();
        t_swap();
        stop_test();
    end
endmodule
